/* File: inc/wdg_pkg.sv */
// Constants and types shared by the windowed guard timer design.
package wdg_pkg;

  // ----------------------------------------------------------------
  // Counter geometry
  // ----------------------------------------------------------------
  localparam int          CNT_W        = 24;
  localparam int          PRE_DIV      = 4;
  localparam int          PRE_W        = 2;
  localparam logic [23:0] CNT_MIN      = 24'h0000FF;
  localparam logic [23:0] CNT_MAX      = 24'hFFFFFF;
  localparam logic [23:0] CNT_RST      = 24'h0000FF;
  localparam logic [23:0] WINDOW_RST   = 24'hFFFFFF;
  localparam logic [9:0]  WARN_RST     = 10'h000;
  localparam logic [23:0] CNT_ZERO     = 24'h000000;
  localparam logic [1:0]  PRE_LAST     = 2'h3;

  // ----------------------------------------------------------------
  // Feed sequence bytes
  // ----------------------------------------------------------------
  localparam logic [7:0]  FEED_FIRST   = 8'hAA;
  localparam logic [7:0]  FEED_SECOND  = 8'h55;

  // ----------------------------------------------------------------
  // Counting clock selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WDG_SRC_INTERNAL_RC = 2'h0,
    WDG_SRC_DEDICATED   = 2'h1,
    WDG_SRC_MAIN        = 2'h2
  } wdg_src_t;

  // Feed sequencer states, Gray coded.
  typedef enum logic [1:0] {
    WDG_FEED_IDLE = 2'h0,
    WDG_FEED_HALF = 2'h1
  } wdg_feed_t;

endpackage

/* File: core/wdg_tick.sv */
// Fixed divide-by-four prescaler for the guard counter.
`timescale 1ns/1ps
module wdg_tick #(
  parameter int DIV = wdg_pkg::PRE_DIV
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic restart,
  input  wire logic tick_in,
  output logic      tick
);

  logic [wdg_pkg::PRE_W-1:0] cnt;
  logic [wdg_pkg::PRE_W-1:0] next_cnt;
  logic                      next_tick;

  // Last prescaler state before a tick, derived from the division ratio.
  localparam int LAST = DIV - 1;

  // Restart realigns the prescaler so every period starts whole.
  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!run || restart) begin
      next_cnt = '0;
    end else if (tick_in) begin
      if (cnt == LAST[wdg_pkg::PRE_W-1:0]) begin
        next_cnt  = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule

/* File: core/wdg_timer.sv */
// Windowed guard timer: 24-bit count, feed check, window and warning.
`timescale 1ns/1ps

module wdg_timer #(
  parameter int          CW         = wdg_pkg::CNT_W,
  parameter bit          WINDOWED   = 1'b1,
  parameter logic [23:0] CNT_RST    = wdg_pkg::CNT_RST,
  parameter logic [23:0] WINDOW_RST = wdg_pkg::WINDOW_RST
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          por_flag_clear,
  input  wire logic          enable_set,
  input  wire logic          int_mode,
  input  wire logic          window_on,
  input  wire logic [1:0]    src_sel,
  input  wire logic          internal_rc_oscillator,
  input  wire logic          dedicated_guard_oscillator,
  input  wire logic          main_clock_tick,
  input  wire logic          reload_we,
  input  wire logic [CW-1:0] reload_value,
  input  wire logic          window_we,
  input  wire logic [CW-1:0] window_value,
  input  wire logic [9:0]    warn_value,
  input  wire logic          feed_we,
  input  wire logic [7:0]    feed_data,
  input  wire logic          int_clear,
  input  wire logic          caused_reset,
  output logic               enabled,
  output logic               sys_reset,
  output logic               timeout_int,
  output logic               warn_int,
  output logic               reset_flag,
  output logic [CW-1:0]      count
);

  // ----------------------------------------------------------------
  // Counting clock selection
  // ----------------------------------------------------------------
  logic guard_count_clock;

  // The windowed variant has no main-clock path; that code then counts
  // nothing, which is safer than silently falling back to another source.
  always_comb begin
    case (src_sel)
      wdg_pkg::WDG_SRC_INTERNAL_RC: guard_count_clock = internal_rc_oscillator;
      wdg_pkg::WDG_SRC_DEDICATED:
        guard_count_clock = dedicated_guard_oscillator;
      wdg_pkg::WDG_SRC_MAIN: guard_count_clock = !WINDOWED && main_clock_tick;
      default: guard_count_clock = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  logic [CW-1:0] reload;
  logic [CW-1:0] window;
  logic [CW-1:0] next_reload;
  logic [CW-1:0] next_window;

  function automatic logic [CW-1:0] clamp_min(input logic [CW-1:0] v);
    clamp_min = (v < CW'(wdg_pkg::CNT_MIN)) ? CW'(wdg_pkg::CNT_MIN) : v;
  endfunction

  always_comb begin
    next_reload = reload;
    next_window = window;
    if (reload_we) begin
      next_reload = clamp_min(reload_value);
    end
    if (window_we) begin
      next_window = window_value;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reload <= CNT_RST;
      window <= WINDOW_RST;
    end else begin
      reload <= next_reload;
      window <= next_window;
    end
  end

  // ----------------------------------------------------------------
  // Feed sequencer
  // ----------------------------------------------------------------
  wdg_pkg::wdg_feed_t feed_st;
  wdg_pkg::wdg_feed_t next_feed_st;
  logic               feed_ok;
  logic               feed_bad;

  always_comb begin
    next_feed_st = feed_st;
    feed_ok      = 1'b0;
    feed_bad     = 1'b0;
    if (feed_we) begin
      case (feed_st)
        wdg_pkg::WDG_FEED_IDLE: begin
          if (feed_data == wdg_pkg::FEED_FIRST) begin
            next_feed_st = wdg_pkg::WDG_FEED_HALF;
          end else begin
            feed_bad = 1'b1;
          end
        end
        wdg_pkg::WDG_FEED_HALF: begin
          next_feed_st = wdg_pkg::WDG_FEED_IDLE;
          if (feed_data == wdg_pkg::FEED_SECOND) begin
            feed_ok = 1'b1;
          end else begin
            feed_bad = 1'b1;
          end
        end
        default: next_feed_st = wdg_pkg::WDG_FEED_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  logic          tick;
  logic          early;
  logic          reload_now;
  logic          violation;
  logic          expire;
  logic [CW-1:0] next_count;

  // A feed with the counter still above the window value is too early.
  assign early      = window_on && (count > window);
  assign reload_now = feed_ok && !early;
  assign violation  = enabled && (feed_bad || (feed_ok && early));

  wdg_tick #(
    .DIV (wdg_pkg::PRE_DIV)
  ) u_tick (
    .clk     (clk),
    .rst     (rst),
    .run     (enabled),
    .restart (reload_now),
    .tick_in (guard_count_clock),
    .tick    (tick)
  );

  assign expire = enabled && tick && (count == CW'(wdg_pkg::CNT_ZERO));

  always_comb begin
    next_count = count;
    if (reload_now || (!enabled && enable_set)) begin
      next_count = reload;
    end else if (tick && enabled && count != CW'(wdg_pkg::CNT_ZERO)) begin
      next_count = count - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Enable, responses and flags
  // ----------------------------------------------------------------
  logic event_hit;
  logic next_enabled;
  logic next_sys_reset;
  logic next_timeout_int;
  logic next_warn_int;
  logic next_reset_flag;
  logic warn_hit;

  assign event_hit = expire || violation;
  assign warn_hit  = enabled && tick && (count == CW'(warn_value));

  always_comb begin
    next_enabled     = enabled;
    next_sys_reset   = 1'b0;
    next_timeout_int = timeout_int;
    next_warn_int    = warn_int;
    next_reset_flag  = reset_flag;
    // Clearing is not offered: software cannot switch the timer off.
    if (enable_set) begin
      next_enabled = 1'b1;
    end
    if (int_clear) begin
      next_timeout_int = 1'b0;
      next_warn_int    = 1'b0;
    end
    if (warn_hit) begin
      next_warn_int = 1'b1;
    end
    if (event_hit) begin
      next_enabled = 1'b0;
      if (int_mode) begin
        next_timeout_int = 1'b1;
      end else begin
        next_sys_reset = 1'b1;
      end
    end
    if (por_flag_clear) begin
      next_reset_flag = 1'b0;
    end
    if (caused_reset) begin
      next_reset_flag = 1'b1;
    end
  end

  // The reset flag must outlive the chip reset this block issues, so it
  // clears only on rst and on por_flag_clear; caused_reset is fed back by the
  // reset controller after the pulse.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      feed_st     <= wdg_pkg::WDG_FEED_IDLE;
      count       <= CNT_RST;
      enabled     <= 1'b0;
      sys_reset   <= 1'b0;
      timeout_int <= 1'b0;
      warn_int    <= 1'b0;
    end else begin
      feed_st     <= next_feed_st;
      count       <= next_count;
      enabled     <= next_enabled;
      sys_reset   <= next_sys_reset;
      timeout_int <= next_timeout_int;
      warn_int    <= next_warn_int;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_flag <= 1'b0;
    end else begin
      reset_flag <= next_reset_flag;
    end
  end

endmodule

/* File: dv/wdg_timer_chk.sv */
// Port-level assertions for the windowed guard timer.
`timescale 1ns/1ps
module wdg_timer_chk #(
  parameter int CW = 24
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          enable_set,
  input wire logic          feed_we,
  input wire logic          int_clear,
  input wire logic          caused_reset,
  input wire logic [9:0]    warn_value,
  input wire logic          enabled,
  input wire logic          sys_reset,
  input wire logic          timeout_int,
  input wire logic          warn_int,
  input wire logic          reset_flag,
  input wire logic [CW-1:0] count
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // An event in the same cycle as the set may legally clear it again.
  en_set_a: assert property (
    enable_set |=> enabled || sys_reset || $rose(timeout_int))
    else $error("enable did not take");
  en_drop_a: assert property (
    $fell(enabled) |-> sys_reset || timeout_int)
    else $error("enable dropped without an event");
  rst_cause_a: assert property (sys_reset |-> $past(enabled))
    else $error("system reset while disabled");
  rst_pulse_a: assert property (sys_reset |=> !sys_reset)
    else $error("system reset longer than one cycle");
  // Any change of a running count other than a reload is a single step down.
  count_dec_a: assert property (enabled && $past(enabled)
    && !$past(enable_set) && !$past(feed_we) && count != $past(count)
    |-> count == CW'($past(count) - 1'b1)) else $error("count jumped");
  step_rate_a: assert property (enabled && $past(enabled)
    && count == CW'($past(count) - 1'b1) |=> $stable(count) [*3])
    else $error("count stepped faster than one per four ticks");
  warn_lvl_a: assert property ($rose(warn_int)
    |-> count <= CW'(warn_value)) else $error("warning too early");
  flag_set_a: assert property (caused_reset |=> reset_flag)
    else $error("reset flag not set");
  int_hold_a: assert property (
    timeout_int && !int_clear |=> timeout_int)
    else $error("interrupt lost");
  cover property (sys_reset);
  cover property ($rose(warn_int));
  cover property ($rose(timeout_int));
endmodule

/* File: dv/windowed_watchdog_timer_bench.sv */
// Self-checking bench for the windowed guard timer.
`timescale 1ns/1ps
module windowed_watchdog_timer_bench;
  logic clk, rst, por_flag_clear, enable_set, int_mode, window_on, run;
  logic reload_we, window_we, feed_we, int_clear, caused_reset;
  logic [1:0] src_sel;
  logic [23:0] reload_value, window_value;
  logic [9:0] warn_value;
  logic [7:0] feed_data;
  logic enabled, sys_reset, timeout_int, warn_int, reset_flag, hit;
  logic [23:0] count;
  int err_total, tests_run, n;
  wdg_timer u_wdg_timer (.clk, .rst, .por_flag_clear, .enable_set, .int_mode,
    .window_on, .src_sel, .internal_rc_oscillator(run),
    .dedicated_guard_oscillator(run), .main_clock_tick(run), .reload_we,
    .reload_value, .window_we, .window_value, .warn_value, .feed_we,
    .feed_data, .int_clear, .caused_reset, .enabled, .sys_reset,
    .timeout_int, .warn_int, .reset_flag, .count);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts cycles until a system reset pulse, giving up after lim cycles.
  // The pulse stands one cycle only, so it is looked at before stepping.
  task automatic wait_rst(input int lim);
    hit = sys_reset;
    for (n = 0; n < lim && !hit; n++) begin
      step(1);
      hit = sys_reset;
    end
  endtask
  // Both bytes go out on back-to-back edges with the strobe held high.
  task automatic feed(input logic [7:0] a, input logic [7:0] b);
    feed_we = 1'b1;
    feed_data = a;
    step(1);
    feed_data = b;
    step(1);
    feed_we = 1'b0;
  endtask
  task automatic arm(input logic [23:0] v);
    reload_value = v;
    reload_we = 1'b1;
    step(1);
    reload_we = 1'b0;
    enable_set = 1'b1;
    step(1);
    enable_set = 1'b0;
  endtask
  task automatic s_enable;
    chk(count, 24'h0000FF);
    arm(24'h000010);
    chk(enabled, 1'b1);
    chk(count, 24'h0000FF);
  endtask
  // The windowed build must ignore the main clock and the unused code.
  task automatic s_sources;
    for (int s = 0; s < 4; s++) begin
      src_sel = s[1:0];
      n = count;
      run = 1'b1;
      step(4);
      run = 1'b0;
      step(3);
      chk(count, n - (s < 2));
    end
    src_sel = 2'h0;
  endtask
  task automatic s_feeds;
    arm(24'h000300);
    feed(8'hAA, 8'h55);
    step(1);
    chk(count, 24'h000300);
    window_value = 24'h000200;
    window_we = 1'b1;
    window_on = 1'b1;
    step(1);
    window_we = 1'b0;
    feed(8'hAA, 8'h55);
    wait_rst(6);
    chk(hit, 1'b1);
    chk(enabled, 1'b0);
    window_on = 1'b0;
    int_mode = 1'b1;
    arm(24'h000300);
    feed(8'hAA, 8'h12);
    wait_rst(6);
    chk(hit, 1'b0);
    chk(timeout_int, 1'b1);
    int_clear = 1'b1;
    step(1);
    int_clear = 1'b0;
    step(1);
    chk(timeout_int, 1'b0);
    int_mode = 1'b0;
  endtask
  task automatic s_window_ok;
    window_on = 1'b1;
    arm(24'h000300);
    run = 1'b1;
    for (int i = 0; i < 1200 && count > 24'h0001FF; i++) step(1);
    run = 1'b0;
    step(4);
    feed(8'hAA, 8'h55);
    wait_rst(4);
    chk(hit, 1'b0);
    chk(count, 24'h000300);
    window_on = 1'b0;
  endtask
  // The shortest period is 256 prescaler steps of four source ticks.
  // The timer is still running here, so enable alone would not reload;
  // a good feed loads the clamped minimum and realigns the prescaler.
  task automatic s_timeout;
    warn_value = 10'h010;
    arm(24'h000001);
    feed(8'hAA, 8'h55);
    run = 1'b1;
    wait_rst(1100);
    run = 1'b0;
    chk(hit, 1'b1);
    chk(n >= 1022 && n <= 1030, 1'b1);
    chk(warn_int, 1'b1);
    caused_reset = 1'b1;
    step(1);
    caused_reset = 1'b0;
    chk(reset_flag, 1'b1);
    por_flag_clear = 1'b1;
    step(1);
    por_flag_clear = 1'b0;
    step(1);
    chk(reset_flag, 1'b0);
  endtask
  task automatic test_done;
    $display("tests %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #40000;
    err_total++;
    test_done;
  end
  initial begin
    {por_flag_clear, enable_set, int_mode, window_on, run} = 5'h00;
    {reload_we, window_we, feed_we, int_clear, caused_reset} = 5'h00;
    {src_sel, feed_data, warn_value} = 20'h00000;
    {reload_value, window_value} = 48'hFFFFFF_FFFFFF;
    err_total = 0;
    tests_run = 0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    s_enable;
    s_sources;
    s_feeds;
    s_window_ok;
    s_timeout;
    test_done;
  end
endmodule
bind wdg_timer wdg_timer_chk #(.CW(CW)) u_wdg_timer_chk (.clk(clk), .rst(rst),
  .enable_set(enable_set), .feed_we(feed_we), .int_clear(int_clear),
  .caused_reset(caused_reset), .warn_value(warn_value), .enabled(enabled),
  .sys_reset(sys_reset), .timeout_int(timeout_int), .warn_int(warn_int),
  .reset_flag(reset_flag), .count(count));
